// [rtl/ssc_pkg.sv]
// package for the serial port suspend control block
package ssc_pkg;
  localparam int          ADDR_WIDTH      = 16;
  // offset is not word aligned: kept as an index, byte address is index times four
  localparam logic [15:0] SUSPEND_CTRL_INDEX = 16'h705f;
  localparam logic [17:0] SUSPEND_CTRL_ADDR  = {SUSPEND_CTRL_INDEX, 2'b00};
  localparam logic [15:0] STATUS_INDEX       = 16'h7060;
  localparam logic [17:0] STATUS_ADDR        = {STATUS_INDEX, 2'b00};
  localparam int          FREE_BIT        = 3;
  localparam int          SOFT_BIT        = 4;
  localparam logic [7:0]  SUSPEND_CTRL_RESET = 8'h00;
  localparam logic [7:0]  SUSPEND_CTRL_MASK  = 8'h18;
  localparam int          STATUS_HALTED_BIT  = 0;
  localparam int          STATUS_PENDING_BIT = 1;

  typedef struct packed {
    logic graceful_stop_select;
    logic run_through_suspend;
  } ssc_mode_type;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b001,
    ST_DRAINING = 3'b010,
    ST_HALTED   = 3'b100
  } ssc_state_type;
endpackage

// [rtl/ssc_sync.sv]
// two flip-flop synchroniser for one level
module ssc_sync
  import ssc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [rtl/ssc_suspend_ctrl.sv]
// suspend control register and halt sequencing for a serial port
// Behaviour
// R1 - unused bits 7-5 and 2-0 read zero, writes to them ignored
// R2 - field 00: suspend request halts serial activity at once
// R3 - field 10: finish the frame in progress, then halt
// R4 - bit 3 set: run on and ignore suspend, whatever bit 4 holds
// R5 - after reset both field bits read zero: immediate stop default
// R6 - on release of suspend the port resumes where it stopped
module ssc_suspend_ctrl
  import ssc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        suspend_req,
  input  wire logic        frame_busy,
  output logic             port_run,
  output logic             port_halted
);
  logic          suspend_sync;
  logic [7:0]    ctrl;
  ssc_mode_type  mode;
  ssc_state_type state;
  ssc_state_type next_state;
  logic          access;
  logic          hit_ctrl;
  logic          hit_status;

  ssc_sync u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (suspend_req),
    .sync_out (suspend_sync)
  );

  assign mode.graceful_stop_select = ctrl[SOFT_BIT];
  assign mode.run_through_suspend  = ctrl[FREE_BIT];

  // zero wait state slave
  assign access     = psel && penable;
  assign hit_ctrl   = (paddr[17:0] == SUSPEND_CTRL_ADDR) && (paddr[31:18] == '0);
  assign hit_status = (paddr[17:0] == STATUS_ADDR) && (paddr[31:18] == '0);
  assign pready     = 1'b1;
  assign pslverr    = access && !(hit_ctrl || hit_status);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl <= SUSPEND_CTRL_RESET; // R5
    end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
      ctrl <= pwdata[7:0] & SUSPEND_CTRL_MASK; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr[17:0] == SUSPEND_CTRL_ADDR && paddr[31:18] == '0) begin
        prdata <= {24'h00_0000, ctrl & SUSPEND_CTRL_MASK}; // R1
      end else if (paddr[17:0] == STATUS_ADDR && paddr[31:18] == '0) begin
        prdata <= {30'h0000_0000, state == ST_DRAINING, state == ST_HALTED};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (suspend_sync && !mode.run_through_suspend) begin // R4
          if (mode.graceful_stop_select && frame_busy) begin
            next_state = ST_DRAINING; // R3
          end else begin
            next_state = ST_HALTED; // R2
          end
        end
      end
      ST_DRAINING: begin
        if (!suspend_sync || mode.run_through_suspend) begin
          next_state = ST_RUN;
        end else if (!frame_busy || !mode.graceful_stop_select) begin
          // a switch to immediate stop mid frame must not wait for the frame
          next_state = ST_HALTED; // R3
        end
      end
      ST_HALTED: begin
        // state of the port is only frozen, never cleared
        if (!suspend_sync || mode.run_through_suspend) begin
          next_state = ST_RUN; // R6
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // the halt is combinational on the synchronised request so mode 00 stops in the same cycle
  assign port_halted = (state == ST_HALTED)
                    || (state == ST_RUN && suspend_sync && !mode.run_through_suspend
                        && !(mode.graceful_stop_select && frame_busy)) // R2
                    || (state == ST_DRAINING && suspend_sync && !mode.run_through_suspend
                        && !mode.graceful_stop_select); // R2
  assign port_run    = !port_halted;

  // mode checks

  a_free_ignores: assert property (@(posedge clk) disable iff (!resetn) // R4
    ctrl[FREE_BIT] |-> port_run)
    else $error("port halted although run through suspend is set");

  a_immediate_stop: assert property (@(posedge clk) disable iff (!resetn) // R2
    (suspend_sync && !ctrl[SOFT_BIT] && !ctrl[FREE_BIT]) |-> port_halted)
    else $error("immediate stop mode did not halt");

  a_graceful_wait: assert property (@(posedge clk) disable iff (!resetn) // R3
    (suspend_sync && ctrl[SOFT_BIT] && !ctrl[FREE_BIT] && frame_busy
      && state != ST_HALTED) |-> port_run)
    else $error("graceful mode halted during a frame");

  a_graceful_halt: assert property (@(posedge clk) disable iff (!resetn) // R3
    (state == ST_DRAINING && suspend_sync && !ctrl[FREE_BIT] && !frame_busy)
      |=> state == ST_HALTED)
    else $error("graceful mode did not halt after frame end");

  a_graceful_idle: assert property (@(posedge clk) disable iff (!resetn) // R3
    (state == ST_RUN && suspend_sync && ctrl[SOFT_BIT] && !ctrl[FREE_BIT]
      && !frame_busy) |-> port_halted)
    else $error("graceful mode did not halt with no frame in progress");

  a_halt_holds: assert property (@(posedge clk) disable iff (!resetn) // R2
    (state == ST_HALTED && suspend_sync && !ctrl[FREE_BIT]) |=> state == ST_HALTED)
    else $error("halt left while suspend still requested");

  a_free_leaves: assert property (@(posedge clk) disable iff (!resetn) // R4
    (state == ST_HALTED && ctrl[FREE_BIT]) |=> state == ST_RUN)
    else $error("setting run through suspend did not leave the halt");

  // resume and halt request checks

  a_resume_run: assert property (@(posedge clk) disable iff (!resetn) // R6
    (state == ST_HALTED && !suspend_sync) |=> port_run)
    else $error("port did not resume after suspend release");

  a_drain_release: assert property (@(posedge clk) disable iff (!resetn) // R6
    (state == ST_DRAINING && !suspend_sync) |=> state == ST_RUN)
    else $error("drain not abandoned after suspend release");

  a_halt_asked: assert property (@(posedge clk) disable iff (!resetn) // R6
    (port_halted && state != ST_HALTED) |-> suspend_sync)
    else $error("port halted with no suspend request");

  // register checks

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn) // R1
    (ctrl & ~SUSPEND_CTRL_MASK) == 8'h00)
    else $error("reserved control bits are set");

  a_reset_value: assert property (@(posedge clk) // R5
    !resetn |=> ctrl == SUSPEND_CTRL_RESET && state == ST_RUN)
    else $error("control not cleared by reset");

  a_write_ctrl: assert property (@(posedge clk) disable iff (!resetn) // R1
    (access && pwrite && hit_ctrl && pstrb[0])
      |=> ctrl == ($past(pwdata[7:0]) & SUSPEND_CTRL_MASK))
    else $error("control write not stored as masked");

  a_strobe_gate: assert property (@(posedge clk) disable iff (!resetn) // R1
    (access && pwrite && !(hit_ctrl && pstrb[0])) |=> $stable(ctrl))
    else $error("control changed by a write that does not hit it");

  a_read_ctrl: assert property (@(posedge clk) disable iff (!resetn) // R1
    (psel && !penable && !pwrite && hit_ctrl)
      |=> prdata == {24'h00_0000, ctrl & SUSPEND_CTRL_MASK})
    else $error("control read returned a wrong value");

  a_read_status: assert property (@(posedge clk) disable iff (!resetn) // R2
    (psel && !penable && !pwrite && hit_status)
      |=> prdata[STATUS_HALTED_BIT] == $past(state == ST_HALTED))
    else $error("status read did not show the halt");

  // scenario covers

  c_immediate: cover property (@(posedge clk) disable iff (!resetn)
    state == ST_RUN ##1 state == ST_HALTED);
  c_free_run: cover property (@(posedge clk) disable iff (!resetn)
    suspend_sync && ctrl[FREE_BIT] && port_run);
  c_draining: cover property (@(posedge clk) disable iff (!resetn)
    state == ST_DRAINING ##[1:20] state == ST_HALTED);
  c_resume: cover property (@(posedge clk) disable iff (!resetn)
    state == ST_HALTED ##1 state == ST_RUN);
endmodule

// [testbench/ssc_emu_model.sv]
// emulation logic model that raises suspend requests
module ssc_emu_model (
  input  wire logic clk,
  input  wire logic halt_cmd,
  output logic      suspend_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // request is a plain level, launched off the clock edge
  always_ff @(posedge clk) begin
    suspend_req <= halt_cmd;
  end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the suspend control block
module testbench;
  import ssc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        halt_cmd, suspend_req, frame_busy, port_run, port_halted;
  int          n_mismatch, checks_done;
  localparam logic [31:0] CA = 32'(SUSPEND_CTRL_ADDR);
  localparam logic [31:0] SA = 32'(STATUS_ADDR);
  ssc_suspend_ctrl ssc_suspend_ctrl_i (.clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .suspend_req,
    .frame_busy, .port_run, .port_halted);
  ssc_emu_model ssc_emu_model_i (.clk, .halt_cmd, .suspend_req);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one zero-or-more wait state transfer, held until pready
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // checks the halt flag n edges on, then realigns to an edge
  task hw(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1;
    chk({31'h0, port_halted}, {31'h0, e});
    chk({31'h0, port_run}, {31'h0, !e});
    @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, halt_cmd, frame_busy} = '0;
    pstrb = 4'hf;
    resetn = 0;
    repeat (10) @(posedge clk);
    resetn <= 1;
    apb(0, CA, 0);
    chk(rd, 0);
    apb(1, CA, 32'hff);
    apb(0, CA, 0);
    chk(rd, 32'h18);
    apb(0, 32'h40, 0);
    chk({31'h0, err}, 1);
    $display("test registers done");
    apb(1, CA, 0);
    halt_cmd <= 1;
    hw(3, 1);
    apb(0, SA, 0);
    chk(rd, 32'h1);
    halt_cmd <= 0;
    hw(4, 0);
    $display("test immediate stop done");
    apb(1, CA, 32'h10);
    frame_busy <= 1;
    halt_cmd <= 1;
    hw(6, 0);
    apb(0, SA, 0);
    chk(rd, 32'h2);
    frame_busy <= 0;
    hw(3, 1);
    halt_cmd <= 0;
    hw(4, 0);
    $display("test graceful stop done");
    // free bit wins whatever the graceful bit holds
    for (int m = 0; m < 2; m++) begin
      apb(1, CA, m ? 32'h18 : 32'h08);
      halt_cmd <= 1;
      hw(6, 0);
      halt_cmd <= 0;
    end
    $display("test free run done");
    pstrb <= 4'h0;
    apb(1, CA, 32'h10);
    pstrb <= 4'hf;
    apb(0, CA, 0);
    chk(rd, 32'h18);
    resetn <= 0;
    repeat (3) @(posedge clk);
    resetn <= 1;
    apb(0, CA, 0);
    chk(rd, 0);
    chk({31'h0, port_run}, 1);
    $display("test strobe and reset done");
    end_of_test();
  end
endmodule
